// *** fine_gain_pkg.sv ***
// Purpose: Shared constants and types for the fine gain control registers
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: Register offsets are word indices; byte address is four times the index
`default_nettype none
package fine_gain_pkg;
	localparam int MAG_W = 4;
	localparam int DIR_BIT = 4;
	localparam int MAG_LSB = 0;
	localparam logic [7:0] TX_FINE_GAIN_IDX = 8'h28;
	localparam logic [7:0] RX_FINE_GAIN_IDX = 8'h29;
	localparam logic [31:0] TX_FINE_GAIN_ADDR = {22'h000000, TX_FINE_GAIN_IDX, 2'h0};
	localparam logic [31:0] RX_FINE_GAIN_ADDR = {22'h000000, RX_FINE_GAIN_IDX, 2'h0};
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// Magnitude unit is one tenth of a dB
	localparam int STEP_TENTHS_DB = 1;

	typedef struct packed {
		logic dir;
		logic [MAG_W-1:0] mag;
	} fine_gain_s;

	localparam fine_gain_s GAIN_RESET = '{dir: 1'b0, mag: 4'h0};
endpackage
`default_nettype wire

// *** fine_gain_apply.sv ***
// Purpose: Turns one fine gain setting into a signed step applied per sample
// Assumes: sample_strobe comes from logic on hclk
// Notes: Step is in tenths of a dB, positive is gain, negative is attenuation
`default_nettype none
module fine_gain_apply #(
	parameter int STEP_W = 5
) (
	input wire logic hclk, // Register clock
	input wire logic hresetn, // Async reset, active low
	input wire logic ce, // Clock enable, freezes state when low
	input wire logic sample_strobe, // One-cycle pulse per processed sample
	input wire fine_gain_pkg::fine_gain_s setting, // Current register setting
	output logic signed [STEP_W-1:0] step // Step in force for this sample
);
	import fine_gain_pkg::*;

	generate
		if (STEP_W < MAG_W + 1) begin : g_bad_width
			$error("STEP_W too narrow for signed magnitude");
		end
	endgenerate

	typedef struct packed {
		logic signed [STEP_W-1:0] step;
	} apply_s;

	apply_s q;
	apply_s d;

	function automatic logic signed [STEP_W-1:0] decode(fine_gain_s g);
		logic signed [STEP_W-1:0] m;
		m = STEP_W'(g.mag) * STEP_W'(STEP_TENTHS_DB);
		if (g.mag == '0) begin
			return '0;
		end
		return g.dir ? -m : m;
	endfunction

	always_comb begin
		d = q;
		// New setting is taken only at a sample boundary
		if (sample_strobe) begin
			d.step = decode(setting);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '{step: '0};
		end else if (ce) begin
			q <= d;
		end
	end

	assign step = q.step;

	a_zero_is_unity: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && sample_strobe && setting.mag == '0) |=> (step == '0))
		else $error("zero magnitude did not give unity step");

	a_dir_sign: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && sample_strobe && setting.mag != '0) |=> ($past(setting.dir) ? (step < 0) : (step > 0)))
		else $error("step sign does not follow direction");

	a_step_size: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && sample_strobe) |=>
		((step < 0 ? -step : step) == STEP_W'($past(setting.mag))))
		else $error("step size does not match magnitude");

	a_hold_between: assert property (@(posedge hclk) disable iff (!hresetn)
		!(ce && sample_strobe) |=> $stable(step))
		else $error("step changed between samples");
endmodule
`default_nettype wire

// *** fine_gain_control_regs.sv ***
// Purpose: AHB-Lite register bank for transmit and receive fine gain
// Assumes: Single master, word transfers, hclk at 25 MHz
// Notes: Zero wait states while ce is high; hreadyout follows ce
//
// Summary of operation
// - Transmit bit 4 chooses gain when 0, attenuation when 1.
// - Transmit bits 3:0 give magnitude in 0.1 dB steps, up to 1.5 dB.
// - Transmit magnitude zero applies 0 dB regardless of direction.
// - Receive bit 4 chooses gain when 0, attenuation when 1.
// - Receive bits 3:0 give magnitude in 0.1 dB steps, up to 1.5 dB.
// - Receive magnitude zero applies 0 dB regardless of direction.
// - Both registers reset to all zeros.
//
// Decided for this implementation: the AHB-Lite slave port.
`default_nettype none
module fine_gain_control_regs #(
	parameter int STEP_W = 5
) (
	input wire logic hclk, // Bus and register clock
	input wire logic hresetn, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	output logic [31:0] hrdata, // Read data
	input wire logic tx_sample_strobe, // Transmit sample boundary
	input wire logic rx_sample_strobe, // Receive sample boundary
	output logic tx_fine_direction, // Transmit direction bit
	output logic [fine_gain_pkg::MAG_W-1:0] tx_fine_magnitude, // Transmit magnitude
	output logic rx_fine_direction, // Receive direction bit
	output logic [fine_gain_pkg::MAG_W-1:0] rx_fine_magnitude, // Receive magnitude
	output logic signed [STEP_W-1:0] tx_fine_step, // Transmit step in force
	output logic signed [STEP_W-1:0] rx_fine_step // Receive step in force
);
	import fine_gain_pkg::*;

	typedef struct packed {
		logic wr_tx;
		logic wr_rx;
		fine_gain_s tx;
		fine_gain_s rx;
		logic [31:0] rdata;
	} regs_s;

	regs_s q;
	regs_s d;
	logic take;
	logic hit_tx;
	logic hit_rx;

	function automatic fine_gain_s from_bus(logic [31:0] w);
		fine_gain_s g;
		g.dir = w[DIR_BIT];
		g.mag = w[MAG_LSB +: MAG_W];
		return g;
	endfunction

	function automatic logic [31:0] to_bus(fine_gain_s g);
		return {27'h0000000, g.dir, g.mag};
	endfunction

	assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
	assign hit_tx = (haddr == TX_FINE_GAIN_ADDR);
	assign hit_rx = (haddr == RX_FINE_GAIN_ADDR);

	always_comb begin
		d = q;
		// Data phase of a write completes this cycle
		if (q.wr_tx) begin
			d.tx = from_bus(hwdata);
		end
		if (q.wr_rx) begin
			d.rx = from_bus(hwdata);
		end
		d.wr_tx = 1'b0;
		d.wr_rx = 1'b0;
		if (take) begin
			d.wr_tx = hwrite && hit_tx && hsize == HSIZE_WORD;
			d.wr_rx = hwrite && hit_rx && hsize == HSIZE_WORD;
			// Read uses d so a write just ahead is seen
			if (!hwrite && hit_tx) begin
				d.rdata = to_bus(d.tx);
			end else if (!hwrite && hit_rx) begin
				d.rdata = to_bus(d.rx);
			end else begin
				d.rdata = 32'h00000000;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '{wr_tx: 1'b0, wr_rx: 1'b0, tx: GAIN_RESET, rx: GAIN_RESET, rdata: 32'h00000000};
		end else if (ce) begin
			q <= d;
		end
	end

	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign tx_fine_direction = q.tx.dir;
	assign tx_fine_magnitude = q.tx.mag;
	assign rx_fine_direction = q.rx.dir;
	assign rx_fine_magnitude = q.rx.mag;

	fine_gain_apply #(
		.STEP_W(STEP_W)
	) u_tx_apply (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.sample_strobe(tx_sample_strobe),
		.setting(q.tx),
		.step(tx_fine_step)
	);

	fine_gain_apply #(
		.STEP_W(STEP_W)
	) u_rx_apply (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.sample_strobe(rx_sample_strobe),
		.setting(q.rx),
		.step(rx_fine_step)
	);

	// Helper: set once any register write has landed
	logic written_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			written_q <= 1'b0;
		end else if (ce && (q.wr_tx || q.wr_rx)) begin
			written_q <= 1'b1;
		end
	end

	a_tx_dir_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && q.wr_tx) |=> (tx_fine_direction == $past(hwdata[DIR_BIT])))
		else $error("transmit direction not written from bit 4");

	a_tx_mag_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && q.wr_tx) |=> (tx_fine_magnitude == $past(hwdata[3:0])))
		else $error("transmit magnitude not written from bits 3:0");

	a_rx_dir_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && q.wr_rx) |=> (rx_fine_direction == $past(hwdata[DIR_BIT])))
		else $error("receive direction not written from bit 4");

	a_rx_mag_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && q.wr_rx) |=> (rx_fine_magnitude == $past(hwdata[3:0])))
		else $error("receive magnitude not written from bits 3:0");

	a_reset_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		!written_q |-> (q.tx == GAIN_RESET && q.rx == GAIN_RESET && tx_fine_step == '0 && rx_fine_step == '0))
		else $error("gain registers not zero before first write");

	a_read_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		hrdata[31:5] == 27'h0000000)
		else $error("unused read bits not zero");

	a_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && take && !hwrite && hit_tx && !q.wr_tx) |=> (hrdata[4:0] == {tx_fine_direction, tx_fine_magnitude}))
		else $error("transmit read data does not match register");

	a_step_on_strobe: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && tx_sample_strobe && tx_fine_magnitude == 4'h0) |=> (tx_fine_step == '0))
		else $error("transmit zero magnitude gave non-unity step");

	// Path checks seen from the top level
	a_rx_step_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && rx_sample_strobe && rx_fine_magnitude == 4'h0) |=> (rx_fine_step == '0))
		else $error("receive zero magnitude gave non-unity step");

	a_tx_step_sign: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && tx_sample_strobe && tx_fine_magnitude != 4'h0) |=>
		($past(tx_fine_direction) ? (tx_fine_step < 0) : (tx_fine_step > 0)))
		else $error("transmit step sign does not follow direction");

	a_rx_step_sign: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && rx_sample_strobe && rx_fine_magnitude != 4'h0) |=>
		($past(rx_fine_direction) ? (rx_fine_step < 0) : (rx_fine_step > 0)))
		else $error("receive step sign does not follow direction");

	a_tx_step_size: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && tx_sample_strobe && !tx_fine_direction) |=>
		(tx_fine_step == $signed({1'b0, $past(tx_fine_magnitude)})))
		else $error("transmit gain step does not match magnitude");

	a_rx_step_size: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && rx_sample_strobe && rx_fine_direction) |=>
		(-rx_fine_step == $signed({1'b0, $past(rx_fine_magnitude)})))
		else $error("receive attenuation step does not match magnitude");

	a_tx_hold_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
		!(ce && q.wr_tx) |=> $stable({tx_fine_direction, tx_fine_magnitude}))
		else $error("transmit register changed without a write");

	a_rx_hold_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
		!(ce && q.wr_rx) |=> $stable({rx_fine_direction, rx_fine_magnitude}))
		else $error("receive register changed without a write");

	// Bus-side checks
	a_rx_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && take && !hwrite && hit_rx && !q.wr_rx) |=> (hrdata[4:0] == {rx_fine_direction, rx_fine_magnitude}))
		else $error("receive read data does not match register");

	a_unmapped_read_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && take && !hwrite && !hit_tx && !hit_rx) |=> (hrdata == 32'h00000000))
		else $error("unmapped read did not return zero");

	a_narrow_write_drop: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && take && hwrite && hsize != HSIZE_WORD) |=> !(q.wr_tx || q.wr_rx))
		else $error("narrow write was accepted");

	a_hrdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!(ce && take) |=> $stable(hrdata))
		else $error("read data changed without an address phase");

	a_freeze_state: assert property (@(posedge hclk) disable iff (!hresetn)
		!ce |=> $stable(q))
		else $error("state changed while clock enable low");
endmodule
`default_nettype wire

// *** fine_gain_control_regs_tb.sv ***
// Purpose: Self-checking bench for the fine gain register bank
// Assumes: Single AHB-Lite master, word transfers except one byte write in scn_narrow, hready fed from hreadyout
// Notes: Steps are checked before and after a sample strobe
`default_nettype none
module fine_gain_control_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fine_gain_pkg::*;
	logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, tx_stb, rx_stb;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic tx_dir, rx_dir;
	logic [MAG_W-1:0] tx_mag, rx_mag;
	logic signed [4:0] tx_step, rx_step;
	int err_total, compares, cyc;
	assign hready = hreadyout;
	fine_gain_control_regs #(.STEP_W(5)) u_fine_gain_control_regs (.hclk(hclk), .hresetn(hresetn), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_sample_strobe(tx_stb),
		.rx_sample_strobe(rx_stb), .tx_fine_direction(tx_dir), .tx_fine_magnitude(tx_mag),
		.rx_fine_direction(rx_dir), .rx_fine_magnitude(rx_mag), .tx_fine_step(tx_step), .rx_fine_step(rx_step));
	task test_done;
		if (err_total == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task strobe(input logic p);
		@(posedge hclk);
		if (p) rx_stb <= 1'b1;
		else tx_stb <= 1'b1;
		@(posedge hclk);
		tx_stb <= 1'b0;
		rx_stb <= 1'b0;
		#1;
	endtask
	task check_path(input logic p, input logic [4:0] v, input logic [4:0] st_old, input logic [4:0] st_new);
		logic [31:0] a, r;
		a = p ? RX_FINE_GAIN_ADDR : TX_FINE_GAIN_ADDR;
		bus(a, 1'b1, {24'hFFFFFF, 3'h7, v}, r);
		bus(a, 1'b0, 32'h0, r);
		chk("readback", {27'h0, v}, r);
		chk("direction", {31'h0, v[4]}, {31'h0, p ? rx_dir : tx_dir});
		chk("magnitude", {28'h0, v[3:0]}, {28'h0, p ? rx_mag : tx_mag});
		chk("step before strobe", {27'h0, st_old}, {27'h0, p ? rx_step : tx_step});
		strobe(p);
		chk("step", {27'h0, st_new}, {27'h0, p ? rx_step : tx_step});
	endtask
	task scn_reset_values;
		logic [31:0] r;
		bus(TX_FINE_GAIN_ADDR, 1'b0, 32'h0, r);
		chk("tx reset value", 32'h0, r);
		bus(RX_FINE_GAIN_ADDR, 1'b0, 32'h0, r);
		chk("rx reset value", 32'h0, r);
		chk("steps at reset", 32'h0, {22'h0, tx_step, rx_step});
	endtask
	task scn_gain(input logic p);
		logic [4:0] vals [5];
		logic [4:0] steps [5];
		logic [4:0] prev;
		vals = '{5'h0F, 5'h11, 5'h1F, 5'h10, 5'h00};
		steps = '{5'h0F, 5'h1F, 5'h11, 5'h00, 5'h00};
		prev = 5'h00;
		for (int i = 0; i < 5; i++) begin
			check_path(p, vals[i], prev, steps[i]);
			prev = steps[i];
		end
	endtask
	task scn_unmapped;
		logic [31:0] r;
		bus(32'h0000_00AC, 1'b1, 32'h0000_001F, r);
		bus(32'h0000_00AC, 1'b0, 32'h0, r);
		chk("unmapped read", 32'h0, r);
		bus(TX_FINE_GAIN_ADDR, 1'b0, 32'h0, r);
		chk("tx after unmapped write", 32'h0, r);
	endtask
	task scn_narrow;
		logic [31:0] r;
		hsize <= 3'h0;
		bus(TX_FINE_GAIN_ADDR, 1'b1, 32'h0000_0015, r);
		hsize <= HSIZE_WORD;
		bus(TX_FINE_GAIN_ADDR, 1'b0, 32'h0, r);
		chk("narrow write ignored", 32'h0, r);
	endtask
	task scn_freeze;
		logic [31:0] r;
		bus(TX_FINE_GAIN_ADDR, 1'b1, 32'h0000_0003, r);
		@(posedge hclk);
		ce <= 1'b0;
		tx_stb <= 1'b1;
		@(posedge hclk);
		tx_stb <= 1'b0;
		#1;
		chk("hreadyout while frozen", 32'h0, {31'h0, hreadyout});
		chk("step while frozen", 32'h0, {27'h0, tx_step});
		@(posedge hclk);
		ce <= 1'b1;
		strobe(1'b0);
		chk("step after freeze", 32'h3, {27'h0, tx_step});
	endtask
	task scn_rereset;
		check_path(1'b0, 5'h1F, 5'h03, 5'h11);
		check_path(1'b1, 5'h0A, 5'h00, 5'h0A);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		scn_reset_values();
	endtask
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		{hresetn, hsel, hwrite, tx_stb, rx_stb, htrans} = '0;
		{haddr, hwdata, err_total, compares, cyc} = '0;
		ce = 1'b1;
		hsize = HSIZE_WORD;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		scn_reset_values();
		scn_gain(1'b0);
		scn_gain(1'b1);
		scn_unmapped();
		scn_narrow();
		scn_freeze();
		scn_rereset();
		test_done();
	end
endmodule
`default_nettype wire
